// ### logic/gip_regs.svh
// constants for the attribute propagation block and its per-port store
// assumes one bridge clock; included by the package and the modules
`ifndef GIP_REGS_SVH
`define GIP_REGS_SVH

`define GIP_N_PORTS       4
`define GIP_TYPE_W        1
`define GIP_VAL_W         4
`define GIP_CTX_BASE      8'h00
`define GIP_CTX_W         8
`define GIP_FLAG_RST      1'b0

`endif

// ### logic/gip_pkg.sv
// types shared by the propagation block and the per-port store
// assumes gip_regs.svh holds the numeric constants
`include "gip_regs.svh"

package gip_pkg;

    // declaration state per attribute
    typedef enum logic [1:0] {
        GIP_APP_OBSERVER,
        GIP_APP_ACTIVE,
        GIP_APP_LEAVING
    } gip_app_state_t;

    // registration state per attribute
    typedef enum logic {
        GIP_REG_EMPTY,
        GIP_REG_IN
    } gip_reg_state_t;

    // propagation sequencer
    typedef enum logic {
        GIP_S_IDLE,
        GIP_S_SCAN
    } gip_fsm_t;

endpackage : gip_pkg

// ### logic/gip_gid.sv
// per-port declaration and registration store
// assumes requests and received events are synchronous to sys_clk_i
`timescale 1ns/1ps
`include "gip_regs.svh"

module gip_gid #(
    parameter int TYPE_W = `GIP_TYPE_W,
    parameter int VAL_W  = `GIP_VAL_W
) (
    input  wire logic              sys_clk_i,     // bridge clock
    input  wire logic              rst_n_i,       // async reset, low
    input  wire logic              prop_valid_i,  // propagation request
    input  wire logic              prop_join_i,   // 1 join, 0 leave
    input  wire logic [TYPE_W+VAL_W-1:0] prop_attr_i, // type and value
    input  wire logic              app_valid_i,   // application request
    input  wire logic              app_join_i,    // 1 join, 0 leave
    input  wire logic [TYPE_W+VAL_W-1:0] app_attr_i,  // type and value
    output logic                   app_ready_o,   // application taken
    input  wire logic              rx_valid_i,    // received event
    input  wire logic              rx_join_i,     // 1 register, 0 deregister
    input  wire logic [TYPE_W+VAL_W-1:0] rx_attr_i,   // type and value
    output logic                   rx_ready_o,    // received event taken
    output logic                   ind_valid_o,   // indication pending
    output logic                   ind_join_o,    // 1 join, 0 leave
    output logic [TYPE_W+VAL_W-1:0] ind_attr_o,   // type and value
    input  wire logic              ind_ready_i,   // indication consumed
    input  wire logic [TYPE_W+VAL_W-1:0] q_attr_i, // state query index
    output gip_pkg::gip_app_state_t q_app_o,      // applicant state
    output gip_pkg::gip_reg_state_t q_reg_o       // registrar state
);

    localparam int AW = TYPE_W + VAL_W;
    localparam int NA = 1 << AW;

    gip_pkg::gip_app_state_t app_st_reg [0:NA-1];
    gip_pkg::gip_reg_state_t reg_st_reg [0:NA-1];
    logic                    req_valid;
    logic                    req_join;
    logic [AW-1:0]           req_attr;
    logic                    rx_take;

    // propagation wins, application waits while a propagation request is valid
    assign app_ready_o = !prop_valid_i;
    assign req_valid   = prop_valid_i || app_valid_i;
    assign req_join    = prop_valid_i ? prop_join_i : app_join_i;
    assign req_attr    = prop_valid_i ? prop_attr_i : app_attr_i;
    assign rx_ready_o  = !ind_valid_o;
    assign rx_take     = rx_valid_i && !ind_valid_o;

    // applicant step on each request
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NA; i++) begin
                app_st_reg[i] <= gip_pkg::GIP_APP_OBSERVER;
            end
        end else if (req_valid) begin
            if (req_join) begin
                app_st_reg[req_attr] <= gip_pkg::GIP_APP_ACTIVE;
            end else if (app_st_reg[req_attr] == gip_pkg::GIP_APP_ACTIVE) begin
                app_st_reg[req_attr] <= gip_pkg::GIP_APP_LEAVING;
            end
        end
    end

    // registrar step on received events
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NA; i++) begin
                reg_st_reg[i] <= gip_pkg::GIP_REG_EMPTY;
            end
        end else if (rx_take) begin
            reg_st_reg[rx_attr_i] <= rx_join_i ? gip_pkg::GIP_REG_IN
                                               : gip_pkg::GIP_REG_EMPTY;
        end
    end

    // indication raised on a registrar change, held until consumed
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ind_valid_o <= 1'b0;
            ind_join_o  <= 1'b0;
            ind_attr_o  <= '0;
        end else if (rx_take && ((reg_st_reg[rx_attr_i] == gip_pkg::GIP_REG_IN) != rx_join_i)) begin
            ind_valid_o <= 1'b1;
            ind_join_o  <= rx_join_i;
            ind_attr_o  <= rx_attr_i;
        end else if (ind_ready_i) begin
            ind_valid_o <= 1'b0;
        end
    end

    // state readback
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_app_o <= gip_pkg::GIP_APP_OBSERVER;
            q_reg_o <= gip_pkg::GIP_REG_EMPTY;
        end else begin
            q_app_o <= app_st_reg[q_attr_i];
            q_reg_o <= reg_st_reg[q_attr_i];
        end
    end

endmodule : gip_gid

// ### logic/gip_prop.sv
// attribute propagation between per-port participants of one context
// assumes all inputs synchronous to sys_clk_i; forwarding set from spanning tree
`timescale 1ns/1ps
`include "gip_regs.svh"

module gip_prop #(
    parameter int N_PORTS = `GIP_N_PORTS,
    parameter int TYPE_W  = `GIP_TYPE_W,
    parameter int VAL_W   = `GIP_VAL_W
) (
    input  wire logic                        sys_clk_i,        // bridge clock
    input  wire logic                        rst_n_i,          // async reset, low
    input  wire logic                        ext_mode_i,       // extended filtering mode
    input  wire logic [N_PORTS-1:0]          fwd_i,            // spanning tree forwarding ports
    output logic [`GIP_CTX_W-1:0]            ctx_id_o,         // context identifier
    output logic [N_PORTS-1:0]               flood_o,          // flood protocol frames per port
    output logic                             busy_o,           // topology rescan running
    input  wire logic [N_PORTS-1:0]          rx_valid_i,       // received event per port
    input  wire logic [N_PORTS-1:0]          rx_join_i,        // 1 register, 0 deregister
    input  wire logic [N_PORTS*TYPE_W-1:0]   rx_type_i,        // attribute type
    input  wire logic [N_PORTS*VAL_W-1:0]    rx_value_i,       // attribute value
    output logic [N_PORTS-1:0]               rx_ready_o,       // received event taken
    input  wire logic [N_PORTS-1:0]          app_req_valid_i,  // application request
    input  wire logic [N_PORTS-1:0]          app_req_join_i,   // 1 join, 0 leave
    input  wire logic [N_PORTS*TYPE_W-1:0]   app_req_type_i,   // attribute type
    input  wire logic [N_PORTS*VAL_W-1:0]    app_req_value_i,  // attribute value
    output logic [N_PORTS-1:0]               app_req_ready_o,  // application request taken
    output logic [N_PORTS-1:0]               app_ind_valid_o,  // indication pulse per port
    output logic                             app_ind_join_o,   // 1 join, 0 leave
    output logic [TYPE_W-1:0]                app_ind_type_o,   // attribute type
    output logic [VAL_W-1:0]                 app_ind_value_o,  // attribute value
    input  wire logic [N_PORTS-1:0]          q_port_i,         // unused width holder per port select
    input  wire logic [TYPE_W+VAL_W-1:0]     q_attr_i,         // state query index
    output logic [N_PORTS*2-1:0]             q_app_o,          // applicant state per port
    output logic [N_PORTS-1:0]               q_reg_o           // registrar state per port
);

    localparam int AW = TYPE_W + VAL_W;
    localparam int NA = 1 << AW;
    localparam int PW = (N_PORTS > 1) ? $clog2(N_PORTS) : 1;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // one-hot mask of a port index
    function automatic logic [N_PORTS-1:0] port_bit(input logic [PW-1:0] p);
        logic [N_PORTS-1:0] m;
        m = '0;
        m[p] = 1'b1;
        return m;
    endfunction : port_bit

    // lowest set bit index
    function automatic logic [PW-1:0] lowest(input logic [N_PORTS-1:0] v);
        logic [PW-1:0] r;
        r = '0;
        for (int i = N_PORTS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = PW'(i);
            end
        end
        return r;
    endfunction : lowest

    ////////////////////////////////////////////////////////////////////////////
    // state

    gip_pkg::gip_fsm_t    state_reg;
    logic [N_PORTS-1:0]   flag_reg [0:NA-1];
    logic [N_PORTS-1:0]   act_set_reg;
    logic [PW-1:0]        chg_port_reg;
    logic [AW-1:0]        scan_idx_reg;
    logic [N_PORTS-1:0]   pr_valid_reg;
    logic                 pr_join_reg;
    logic [AW-1:0]        pr_attr_reg;
    logic [N_PORTS-1:0]   ind_valid;
    logic [N_PORTS-1:0]   ind_join;
    logic [AW-1:0]        ind_attr [0:N_PORTS-1];
    logic [N_PORTS-1:0]   ind_ready;
    logic [N_PORTS-1:0]   chg;
    logic                 ind_take;
    logic [PW-1:0]        ind_port;
    logic [N_PORTS-1:0]   ind_mask;
    logic [AW-1:0]        cur_attr;
    logic                 cur_join;
    logic [N_PORTS-1:0]   holders;
    logic [N_PORTS-1:0]   others;

    ////////////////////////////////////////////////////////////////////////////
    // per-port participants

    // one participant per port for this context
    for (genvar g = 0; g < N_PORTS; g++) begin : g_port
        gip_gid #(
            .TYPE_W (TYPE_W),
            .VAL_W  (VAL_W)
        ) u_gid (
            .sys_clk_i    (sys_clk_i),
            .rst_n_i      (rst_n_i),
            .prop_valid_i (pr_valid_reg[g]),
            .prop_join_i  (pr_join_reg),
            .prop_attr_i  (pr_attr_reg),
            .app_valid_i  (app_req_valid_i[g]),
            .app_join_i   (app_req_join_i[g]),
            .app_attr_i   ({app_req_type_i[g*TYPE_W +: TYPE_W], app_req_value_i[g*VAL_W +: VAL_W]}),
            .app_ready_o  (app_req_ready_o[g]),
            .rx_valid_i   (rx_valid_i[g]),
            .rx_join_i    (rx_join_i[g]),
            .rx_attr_i    ({rx_type_i[g*TYPE_W +: TYPE_W], rx_value_i[g*VAL_W +: VAL_W]}),
            .rx_ready_o   (rx_ready_o[g]),
            .ind_valid_o  (ind_valid[g]),
            .ind_join_o   (ind_join[g]),
            .ind_attr_o   (ind_attr[g]),
            .ind_ready_i  (ind_ready[g]),
            .q_attr_i     (q_attr_i),
            .q_app_o      (q_app_o[g*2 +: 2]),
            .q_reg_o      (q_reg_o[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // indication arbitration and propagation decisions

    // pending membership changes of the forwarding set
    assign chg = ext_mode_i ? (fwd_i ^ act_set_reg) : '0;

    // take one indication while idle and no membership change waits
    assign ind_take  = (state_reg == gip_pkg::GIP_S_IDLE) && (chg == '0) && (ind_valid != '0);
    assign ind_port  = lowest(ind_valid);
    assign ind_mask  = port_bit(ind_port);
    assign ind_ready = ind_take ? ind_mask : '0;
    assign cur_attr  = ind_attr[ind_port];
    assign cur_join  = ind_join[ind_port];

    // active ports other than the source that still hold the attribute
    assign holders = flag_reg[cur_attr] & act_set_reg & ~ind_mask;
    assign others  = act_set_reg & ~ind_mask;

    assign ctx_id_o = `GIP_CTX_BASE;
    assign busy_o   = (state_reg == gip_pkg::GIP_S_SCAN);

    ////////////////////////////////////////////////////////////////////////////
    // registration flags, kept on every port regardless of forwarding

    // set on join indication, clear on leave indication
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NA; i++) begin
                flag_reg[i] <= {N_PORTS{`GIP_FLAG_RST}};
            end
        end else if (ind_take) begin
            flag_reg[cur_attr][ind_port] <= cur_join;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // propagation requests, one cycle pulse per target port

    // compute targets from indications or from the topology rescan
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pr_valid_reg <= '0;
            pr_join_reg  <= 1'b0;
            pr_attr_reg  <= '0;
        end else begin
            pr_valid_reg <= '0;
            if (ext_mode_i && ind_take && act_set_reg[ind_port]) begin
                pr_join_reg <= cur_join;
                pr_attr_reg <= cur_attr;
                if (cur_join) begin
                    pr_valid_reg <= others;
                end else begin
                    for (int q = 0; q < N_PORTS; q++) begin
                        // leave only if nobody but q still holds it
                        pr_valid_reg[q] <= others[q]
                            && ((holders & ~port_bit(PW'(q))) == '0);
                    end
                end
            end else if (ext_mode_i && state_reg == gip_pkg::GIP_S_SCAN
                         && flag_reg[scan_idx_reg][chg_port_reg]) begin
                pr_join_reg  <= fwd_i[chg_port_reg];
                pr_attr_reg  <= scan_idx_reg;
                pr_valid_reg <= act_set_reg & ~port_bit(chg_port_reg);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // forwarding set tracking and rescan sequencer

    // one changed port at a time, every attribute visited once
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg    <= gip_pkg::GIP_S_IDLE;
            act_set_reg  <= '0;
            chg_port_reg <= '0;
            scan_idx_reg <= '0;
        end else if (!ext_mode_i) begin
            state_reg    <= gip_pkg::GIP_S_IDLE;
            act_set_reg  <= '0;
            scan_idx_reg <= '0;
        end else begin
            case (state_reg)
                gip_pkg::GIP_S_IDLE: begin
                    if (chg != '0) begin
                        chg_port_reg <= lowest(chg);
                        scan_idx_reg <= '0;
                        state_reg    <= gip_pkg::GIP_S_SCAN;
                    end
                end
                gip_pkg::GIP_S_SCAN: begin
                    if (scan_idx_reg == AW'(NA - 1)) begin
                        act_set_reg[chg_port_reg] <= fwd_i[chg_port_reg];
                        state_reg <= gip_pkg::GIP_S_IDLE;
                    end
                    scan_idx_reg <= scan_idx_reg + AW'(1);
                end
                default: begin
                    state_reg <= gip_pkg::GIP_S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // application side indications and frame flooding

    // every consumed indication is also shown to the application
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            app_ind_valid_o <= '0;
            app_ind_join_o  <= 1'b0;
            app_ind_type_o  <= '0;
            app_ind_value_o <= '0;
        end else begin
            app_ind_valid_o <= ind_ready;
            if (ind_take) begin
                app_ind_join_o  <= cur_join;
                app_ind_type_o  <= cur_attr[AW-1 -: TYPE_W];
                app_ind_value_o <= cur_attr[VAL_W-1:0];
            end
        end
    end

    // transparent bridge floods protocol frames on forwarding ports in basic mode only, none in extended mode
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flood_o <= '0;
        end else begin
            flood_o <= ext_mode_i ? '0 : fwd_i;
        end
    end

endmodule : gip_prop

// ### dv/gip_prop_chk.sv
// checker: port assertions for the propagation block
// assumes bind into gip_prop, one clock domain
`timescale 1ns/1ps
`include "gip_regs.svh"

module gip_prop_chk #(
    parameter int N_PORTS = 4,
    parameter int TYPE_W  = 1,
    parameter int VAL_W   = 4
) (
    input wire logic                  sys_clk_i,       // clock
    input wire logic                  rst_n_i,         // reset, low
    input wire logic                  ext_mode_i,      // extended mode
    input wire logic [N_PORTS-1:0]    fwd_i,           // forwarding set
    input wire logic [`GIP_CTX_W-1:0] ctx_id_o,        // context id
    input wire logic [N_PORTS-1:0]    flood_o,         // flood per port
    input wire logic                  busy_o,          // rescan
    input wire logic [N_PORTS-1:0]    rx_ready_o,      // rx taken
    input wire logic [N_PORTS-1:0]    app_req_valid_i, // app request
    input wire logic [N_PORTS-1:0]    app_req_ready_o, // app taken
    input wire logic [N_PORTS-1:0]    app_ind_valid_o, // indication
    input wire logic                  app_ind_join_o,  // join flag
    input wire logic [TYPE_W-1:0]     app_ind_type_o,  // type
    input wire logic [VAL_W-1:0]      app_ind_value_o  // value
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////
    // port relations
    property p_ctx_zero;
        ctx_id_o == 8'h00;
    endproperty
    a_ctx_zero: assert property (p_ctx_zero) else $error("context id not zero");
    property p_flood;
        $past(rst_n_i) |-> flood_o == ($past(ext_mode_i) ? {N_PORTS{1'b0}} : $past(fwd_i));
    endproperty
    a_flood: assert property (p_flood) else $error("flood does not follow mode");
    property p_ind_onehot;
        $onehot0(app_ind_valid_o);
    endproperty
    a_ind_onehot: assert property (p_ind_onehot) else $error("two indications at once");
    property p_ind_pending;
        $past(rst_n_i) |-> (app_ind_valid_o & $past(rx_ready_o)) == '0;
    endproperty
    a_ind_pending: assert property (p_ind_pending) else $error("indication without pending");
    property p_ind_ready;
        (app_ind_valid_o & ~rx_ready_o) == '0;
    endproperty
    a_ind_ready: assert property (p_ind_ready) else $error("ready low at indication");
    property p_ind_hold;
        $past(rst_n_i) && app_ind_valid_o == '0 |-> $stable({app_ind_join_o, app_ind_type_o, app_ind_value_o});
    endproperty
    a_ind_hold: assert property (p_ind_hold) else $error("indication fields moved");
    property p_basic_ready;
        !ext_mode_i && !$past(ext_mode_i) && !$past(ext_mode_i, 2) |-> &app_req_ready_o;
    endproperty
    a_basic_ready: assert property (p_basic_ready) else $error("propagation in basic mode");
    property p_busy_end;
        $rose(busy_o) |-> ##[1:300] !busy_o;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("rescan does not end");
    property p_no_ind_busy;
        $past(rst_n_i) && app_ind_valid_o != '0 |-> !$past(busy_o);
    endproperty
    a_no_ind_busy: assert property (p_no_ind_busy) else $error("indication during rescan");

    // main scenarios seen
    c_ind: cover property (app_ind_valid_o != '0);
    c_scan: cover property ($rose(busy_o));
    c_app: cover property ((app_req_valid_i & app_req_ready_o) != '0);
endmodule : gip_prop_chk

bind gip_prop gip_prop_chk #(.N_PORTS(N_PORTS), .TYPE_W(TYPE_W), .VAL_W(VAL_W)) gip_prop_chk_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ext_mode_i(ext_mode_i), .fwd_i(fwd_i),
    .ctx_id_o(ctx_id_o), .flood_o(flood_o), .busy_o(busy_o), .rx_ready_o(rx_ready_o),
    .app_req_valid_i(app_req_valid_i), .app_req_ready_o(app_req_ready_o),
    .app_ind_valid_o(app_ind_valid_o), .app_ind_join_o(app_ind_join_o),
    .app_ind_type_o(app_ind_type_o), .app_ind_value_o(app_ind_value_o)
);

// ### dv/gip_peer.sv
// partner: received registration events per port
// assumes send is called at a falling edge
`timescale 1ns/1ps

module gip_peer #(
    parameter int N_PORTS = 4,
    parameter int TYPE_W  = 1,
    parameter int VAL_W   = 4
) (
    input  wire logic                  sys_clk_i,  // clock
    input  wire logic [N_PORTS-1:0]    rx_ready_i, // event taken
    output logic [N_PORTS-1:0]         rx_valid_o, // event valid
    output logic [N_PORTS-1:0]         rx_join_o,  // 1 register
    output logic [N_PORTS*TYPE_W-1:0]  rx_type_o,  // type
    output logic [N_PORTS*VAL_W-1:0]   rx_value_o  // value
);
    // idle lines at time zero
    initial begin
        rx_valid_o = '0;
        rx_join_o = '0;
        rx_type_o = '0;
        rx_value_o = '0;
    end

    // one event, held until taken, then lines scrambled
    task automatic send(input int p, input logic jn, input logic [TYPE_W+VAL_W-1:0] attr);
        int n;
        n = 0;
        rx_valid_o[p] = 1'b1;
        rx_join_o[p] = jn;
        {rx_type_o[p*TYPE_W +: TYPE_W], rx_value_o[p*VAL_W +: VAL_W]} = attr;
        while (rx_ready_i[p] !== 1'b1 && n < 64) begin
            @(negedge sys_clk_i);
            n++;
        end
        @(negedge sys_clk_i);
        rx_valid_o[p] = 1'b0;
        rx_join_o[p] = ~jn;
        {rx_type_o[p*TYPE_W +: TYPE_W], rx_value_o[p*VAL_W +: VAL_W]} = ~attr;
    endtask : send
endmodule : gip_peer

// ### dv/tb_top.sv
// testbench: propagation scenarios at the block ports
// assumes gip_peer gives received events, bench acts as application
`timescale 1ns/1ps

module tb_top;
    localparam int N = 4;
    localparam int VW = 4;
    logic            sys_clk_i, rst_n_i, ext_mode_i, busy, app_ind_join, app_ind_type;
    logic [N-1:0]    fwd_i, flood_o, rx_valid, rx_join, rx_type, rx_ready, q_reg;
    logic [N-1:0]    app_req_valid, app_req_join, app_req_type, app_req_ready, app_ind_valid;
    logic [N*VW-1:0] rx_value, app_req_value;
    logic [7:0]      ctx_id, q_app;
    logic [VW-1:0]   app_ind_value;
    logic [4:0]      q_attr;
    int              error_cnt, total_checks, cyc;

    gip_prop #(.N_PORTS(N), .TYPE_W(1), .VAL_W(VW)) gip_prop_i (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ext_mode_i(ext_mode_i), .fwd_i(fwd_i),
        .ctx_id_o(ctx_id), .flood_o(flood_o), .busy_o(busy), .rx_valid_i(rx_valid),
        .rx_join_i(rx_join), .rx_type_i(rx_type), .rx_value_i(rx_value), .rx_ready_o(rx_ready),
        .app_req_valid_i(app_req_valid), .app_req_join_i(app_req_join), .app_req_type_i(app_req_type),
        .app_req_value_i(app_req_value), .app_req_ready_o(app_req_ready), .app_ind_valid_o(app_ind_valid),
        .app_ind_join_o(app_ind_join), .app_ind_type_o(app_ind_type), .app_ind_value_o(app_ind_value),
        .q_port_i(4'h0), .q_attr_i(q_attr), .q_app_o(q_app), .q_reg_o(q_reg)
    );
    gip_peer #(.N_PORTS(N), .TYPE_W(1), .VAL_W(VW)) gip_peer_i (
        .sys_clk_i(sys_clk_i), .rx_ready_i(rx_ready), .rx_valid_o(rx_valid),
        .rx_join_o(rx_join), .rx_type_o(rx_type), .rx_value_o(rx_value)
    );

    ////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt = error_cnt + 1;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_app(input logic [4:0] attr, input logic [7:0] exp);
        q_attr = attr;
        repeat (2) @(negedge sys_clk_i);
        chk_val(q_app, exp);
    endtask : chk_app
    task automatic chk_reg(input logic [4:0] attr, input logic [7:0] exp);
        q_attr = attr;
        repeat (2) @(negedge sys_clk_i);
        chk_val({4'h0, q_reg}, exp);
    endtask : chk_reg
    task automatic wait_ind(input int p, input logic jn, input logic [4:0] attr);
        int n;
        n = 0;
        while (app_ind_valid[p] !== 1'b1 && n < 40) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk_val({7'h00, app_ind_valid[p]}, 8'h01);
        chk_val({2'h0, app_ind_join, app_ind_type, app_ind_value}, {2'h0, jn, attr});
    endtask : wait_ind
    // rescans of several ports leave one idle cycle between them
    task automatic wait_idle();
        int n;
        int quiet;
        n = 0;
        quiet = 0;
        repeat (3) @(negedge sys_clk_i);
        while (quiet < 2 && n < 400) begin
            quiet = (busy === 1'b0) ? quiet + 1 : 0;
            @(negedge sys_clk_i);
            n++;
        end
        chk_val({7'h00, busy}, 8'h00);
    endtask : wait_idle
    task automatic app_req(input int p, input logic jn, input logic [4:0] attr);
        int n;
        n = 0;
        app_req_valid[p] = 1'b1;
        app_req_join[p] = jn;
        {app_req_type[p], app_req_value[p*VW +: VW]} = attr;
        while (app_req_ready[p] !== 1'b1 && n < 64) begin
            @(negedge sys_clk_i);
            n++;
        end
        @(negedge sys_clk_i);
        app_req_valid[p] = 1'b0;
    endtask : app_req
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////
    // scenarios, attributes a=03 b=1a c=07
    task automatic t_basic();
        chk_val(ctx_id, 8'h00);
        chk_app(5'h03, 8'h00);
        fwd_i = 4'h7;
        repeat (2) @(negedge sys_clk_i);
        chk_val({4'h0, flood_o}, 8'h07);
        gip_peer_i.send(0, 1'b1, 5'h03);
        wait_ind(0, 1'b1, 5'h03);
        chk_app(5'h03, 8'h00);
        chk_reg(5'h03, 8'h01);
        gip_peer_i.send(0, 1'b0, 5'h03);
        wait_ind(0, 1'b0, 5'h03);
        chk_reg(5'h03, 8'h00);
    endtask : t_basic
    task automatic t_join();
        ext_mode_i = 1'b1;
        wait_idle();
        chk_val({4'h0, flood_o}, 8'h00);
        gip_peer_i.send(0, 1'b1, 5'h03);
        wait_ind(0, 1'b1, 5'h03);
        chk_app(5'h03, 8'h14);
        gip_peer_i.send(3, 1'b1, 5'h03);
        wait_ind(3, 1'b1, 5'h03);
        chk_app(5'h03, 8'h14);
        chk_reg(5'h03, 8'h09);
        fwd_i = 4'hf;
        wait_idle();
        chk_app(5'h03, 8'h15);
        fwd_i = 4'h7;
        wait_idle();
        chk_app(5'h03, 8'h2a);
    endtask : t_join
    task automatic t_leave();
        gip_peer_i.send(0, 1'b1, 5'h1a);
        wait_ind(0, 1'b1, 5'h1a);
        gip_peer_i.send(1, 1'b1, 5'h1a);
        wait_ind(1, 1'b1, 5'h1a);
        chk_app(5'h1a, 8'h15);
        gip_peer_i.send(0, 1'b0, 5'h1a);
        wait_ind(0, 1'b0, 5'h1a);
        chk_app(5'h1a, 8'h19);
        chk_app(5'h03, 8'h2a);
        app_req(3, 1'b1, 5'h07);
        chk_app(5'h07, 8'h40);
        app_req(3, 1'b0, 5'h07);
        chk_app(5'h07, 8'h80);
    endtask : t_leave

    // main sequence
    initial begin
        error_cnt = 0;
        total_checks = 0;
        cyc = 0;
        rst_n_i = 1'b0;
        ext_mode_i = 1'b0;
        fwd_i = 4'h0;
        app_req_valid = '0;
        app_req_join = '0;
        app_req_type = '0;
        app_req_value = '0;
        q_attr = '0;
        repeat (12) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        t_basic();
        t_join();
        t_leave();
        finish_test();
    end
endmodule : tb_top
